/* File: core/pcc_top.sv */
// pwm cycle configuration register, overflow flag and reload bank
module pcc_top
  import pcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_rdata_valid,
  input wire logic [PCC_CNT_W-1:0] main_counter,
  input wire logic counter_tick,
  input wire logic [PCC_CHANNELS-1:0] channel_pwm_enable,
  input wire logic [PCC_CHANNELS-1:0] wide_pwm_select,
  input wire logic [PCC_CNT_W-1:0] compare_value [PCC_CHANNELS],
  output logic compare_wr,
  output logic [PCC_CHAN_W-1:0] compare_wr_chan,
  output logic compare_wr_high,
  output logic [7:0] compare_wr_data,
  output logic [PCC_CNT_W-1:0] reload_value [PCC_CHANNELS],
  output logic [PCC_CHANNELS-1:0] reload_active,
  output logic [PCC_CHANNELS-1:0] uses_cycle_length,
  output logic reload_bank_select,
  output logic cycle_overflow_irq_enable,
  output logic cycle_overflow_flag,
  output pcc_len_type cycle_length_select,
  output logic counter_array_irq
);

  pcc_ovf_if ovf ();

  logic cfg_hit;
  logic cfg_wr;
  logic cfg_rd;
  logic [PCC_CHANNELS-1:0] hit_low;
  logic [PCC_CHANNELS-1:0] hit_high;
  logic cmp_hit;
  logic [PCC_CHAN_W-1:0] hit_chan;
  logic hit_is_high;
  logic [7:0] cfg_read;
  logic [7:0] cmp_read;
  logic [7:0] rld_read;
  logic next_flag;
  logic next_irq_en;
  logic [7:0] reload_low [PCC_CHANNELS];
  logic [7:0] reload_high [PCC_CHANNELS];

  // rollover detector on the main counter
  assign ovf.count = main_counter;
  assign ovf.tick = counter_tick;
  assign ovf.length = cycle_length_select;

  pcc_overflow u_overflow (
    .ovf(ovf.det)
  );

  // configuration register decode
  assign cfg_hit = (sfr_addr == PCC_CFG_ADDR);
  assign cfg_wr = sfr_wr & cfg_hit;
  assign cfg_rd = sfr_rd & cfg_hit;

  // compare-value address decode per channel
  always_comb begin
    hit_low = '0;
    hit_high = '0;
    hit_chan = '0;
    hit_is_high = 1'b0;
    for (int n = 0; n < PCC_CHANNELS; n++) begin
      hit_low[n] = (sfr_addr == PCC_CMP_LOW_ADDR[n]);
      hit_high[n] = (sfr_addr == PCC_CMP_HIGH_ADDR[n]);
      if (hit_low[n] | hit_high[n]) begin
        hit_chan = PCC_CHAN_W'(n);
        hit_is_high = hit_high[n];
      end
    end
  end
  assign cmp_hit = |{hit_low, hit_high};

  // configuration read image, unused bits forced low
  assign cfg_read = {reload_bank_select, cycle_overflow_irq_enable, cycle_overflow_flag,
                     PCC_UNUSED_READ, cycle_length_select};

  // read images of the two banks at the decoded address
  assign cmp_read = hit_is_high ? compare_value[hit_chan][15:8]
                                : compare_value[hit_chan][7:0];
  assign rld_read = hit_is_high ? reload_high[hit_chan] : reload_low[hit_chan];

  // flag: hardware set wins over a software clear
  assign next_flag = ovf.rollover
                   | (cfg_wr ? sfr_wdata[PCC_FLAG_BIT] : cycle_overflow_flag);
  assign next_irq_en = cfg_wr ? sfr_wdata[PCC_IRQEN_BIT] : cycle_overflow_irq_enable;

  // bank select, interrupt enable and cycle length fields
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reload_bank_select <= PCC_CFG_RESET[PCC_BANK_BIT];
      cycle_overflow_irq_enable <= PCC_CFG_RESET[PCC_IRQEN_BIT];
      cycle_length_select <= pcc_len_type'(PCC_CFG_RESET[PCC_LEN_MSB:PCC_LEN_LSB]);
    end else if (ce && cfg_wr) begin
      // bits 4:2 are dropped here
      reload_bank_select <= sfr_wdata[PCC_BANK_BIT];
      cycle_overflow_irq_enable <= sfr_wdata[PCC_IRQEN_BIT];
      cycle_length_select <= pcc_len_type'(sfr_wdata[PCC_LEN_MSB:PCC_LEN_LSB]);
    end
  end

  // cycle overflow flag, sticky until a software write of zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cycle_overflow_flag <= PCC_CFG_RESET[PCC_FLAG_BIT];
    end else if (ce) begin
      cycle_overflow_flag <= next_flag;
    end
  end

  // interrupt request follows flag and enable together
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      counter_array_irq <= 1'b0;
    end else if (ce) begin
      counter_array_irq <= next_flag & next_irq_en;
    end
  end

  // reload bank writes when the bank select points at it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int n = 0; n < PCC_CHANNELS; n++) begin
        reload_low[n] <= PCC_RELOAD_RESET;
        reload_high[n] <= PCC_RELOAD_RESET;
      end
    end else if (ce && sfr_wr && reload_bank_select == PCC_BANK_RELOAD) begin
      for (int n = 0; n < PCC_CHANNELS; n++) begin
        if (hit_low[n]) begin
          reload_low[n] <= sfr_wdata;
        end
        if (hit_high[n]) begin
          reload_high[n] <= sfr_wdata;
        end
      end
    end
  end

  // reload values presented to the channels
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int n = 0; n < PCC_CHANNELS; n++) begin
        reload_value[n] <= '0;
      end
    end else if (ce) begin
      for (int n = 0; n < PCC_CHANNELS; n++) begin
        reload_value[n] <= {reload_high[n], reload_low[n]};
      end
    end
  end

  // compare bank writes passed on to the channel registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      compare_wr <= 1'b0;
      compare_wr_chan <= '0;
      compare_wr_high <= 1'b0;
      compare_wr_data <= '0;
    end else if (ce) begin
      compare_wr <= sfr_wr & cmp_hit & (reload_bank_select == PCC_BANK_COMPARE);
      if (sfr_wr && cmp_hit) begin
        compare_wr_chan <= hit_chan;
        compare_wr_high <= hit_is_high;
        compare_wr_data <= sfr_wdata;
      end
    end
  end

  // read answer, one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sfr_rdata <= '0;
      sfr_rdata_valid <= 1'b0;
    end else if (ce) begin
      sfr_rdata_valid <= cfg_rd | (sfr_rd & cmp_hit);
      if (cfg_rd) begin
        sfr_rdata <= cfg_read;
      end else if (sfr_rd && cmp_hit) begin
        sfr_rdata <= (reload_bank_select == PCC_BANK_RELOAD) ? rld_read : cmp_read;
      end
    end
  end

  // per-channel use of the cycle length and of the reload bank
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      uses_cycle_length <= '0;
      reload_active <= '0;
    end else if (ce) begin
      for (int n = 0; n < PCC_CHANNELS; n++) begin
        // wide channels ignore the selected length
        uses_cycle_length[n] <= channel_pwm_enable[n] & ~wide_pwm_select[n];
        // reload only matters beyond the 8-bit cycle
        reload_active[n] <= channel_pwm_enable[n] & ~wide_pwm_select[n]
                          & (cycle_length_select != PCC_LEN8);
      end
    end
  end

endmodule

/* File: shared/pcc_pkg.sv */
// constants and types for the pwm cycle configuration block
package pcc_pkg;

  // channel count and widths
  localparam int PCC_CHANNELS = 3;
  localparam int PCC_CNT_W = 16;
  localparam int PCC_LOW_W = 11;
  localparam int PCC_CHAN_W = 2;

  // configuration register address and reset value
  localparam logic [7:0] PCC_CFG_ADDR = 8'hF7;
  localparam logic [7:0] PCC_CFG_RESET = 8'h00;

  // configuration register field positions
  localparam int PCC_BANK_BIT = 7;
  localparam int PCC_IRQEN_BIT = 6;
  localparam int PCC_FLAG_BIT = 5;
  localparam int PCC_LEN_LSB = 0;
  localparam int PCC_LEN_MSB = 1;
  localparam logic [2:0] PCC_UNUSED_READ = 3'h0;

  // bank select values
  localparam logic PCC_BANK_COMPARE = 1'b0;
  localparam logic PCC_BANK_RELOAD = 1'b1;

  // cycle length codes
  typedef enum logic [1:0] {
    PCC_LEN8 = 2'h0,
    PCC_LEN9 = 2'h1,
    PCC_LEN10 = 2'h2,
    PCC_LEN11 = 2'h3
  } pcc_len_type;

  // low-bit masks of the main counter, indexed by length code
  localparam logic [PCC_LOW_W-1:0] PCC_LEN_MASK [4] = '{
    11'h0FF, 11'h1FF, 11'h3FF, 11'h7FF
  };

  // compare-value byte addresses per channel
  localparam logic [7:0] PCC_CMP_LOW_ADDR [PCC_CHANNELS] = '{8'hE9, 8'hEB, 8'hED};
  localparam logic [7:0] PCC_CMP_HIGH_ADDR [PCC_CHANNELS] = '{8'hEA, 8'hEC, 8'hEE};

  // reset values of the reload bank
  localparam logic [7:0] PCC_RELOAD_RESET = 8'h00;

endpackage

/* File: shared/pcc_ovf_if.sv */
// carrier between the configuration top and the rollover detector
interface pcc_ovf_if;
  import pcc_pkg::*;
  logic [PCC_CNT_W-1:0] count;
  logic tick;
  pcc_len_type length;
  logic rollover;
  modport top (output count, output tick, output length, input rollover);
  modport det (input count, input tick, input length, output rollover);
endinterface

/* File: core/pcc_overflow.sv */
// rollover detector for the selected low bits of the main counter
module pcc_overflow
  import pcc_pkg::*;
(
  pcc_ovf_if.det ovf
);

  logic [PCC_LOW_W-1:0] mask;
  logic [PCC_LOW_W-1:0] low_bits;

  // mask of the bits that make up one pwm cycle
  assign mask = PCC_LEN_MASK[ovf.length];
  assign low_bits = ovf.count[PCC_LOW_W-1:0];

  // all ones on a counting edge means the next value wraps to zero
  assign ovf.rollover = ovf.tick & ((low_bits & mask) == mask);

endmodule

/* File: tb/pcc_monitor.sv */
// assertion checker for the pwm cycle configuration ports
module pcc_monitor
  import pcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rdata_valid,
  input wire logic [PCC_CNT_W-1:0] main_counter,
  input wire logic counter_tick,
  input wire logic [PCC_CHANNELS-1:0] channel_pwm_enable,
  input wire logic [PCC_CHANNELS-1:0] wide_pwm_select,
  input wire logic compare_wr,
  input wire logic [PCC_CHANNELS-1:0] reload_active,
  input wire logic reload_bank_select,
  input wire logic cycle_overflow_irq_enable,
  input wire logic cycle_overflow_flag,
  input wire pcc_len_type cycle_length_select,
  input wire logic counter_array_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic hit;
  logic cfg_wr;
  // rollover of the selected low counter bits, config write strobe
  assign hit = ce && counter_tick && ((main_counter[10:0] & PCC_LEN_MASK[cycle_length_select])
    == PCC_LEN_MASK[cycle_length_select]);
  assign cfg_wr = ce && sfr_wr && sfr_addr == PCC_CFG_ADDR;
  a_roll_sets_flag: assert property (hit |=> cycle_overflow_flag)
    else $error("flag not set on rollover");
  a_flag_holds: assert property (cycle_overflow_flag && !(cfg_wr && !sfr_wdata[5])
    |=> cycle_overflow_flag) else $error("flag cleared without write");
  a_flag_clears: assert property (cfg_wr && !sfr_wdata[5] && !hit
    |=> !cycle_overflow_flag) else $error("flag not cleared");
  a_irq_mask: assert property (counter_array_irq ==
    (cycle_overflow_flag && cycle_overflow_irq_enable)) else $error("irq wrong");
  a_unused_zero: assert property (ce && sfr_rd && sfr_addr == PCC_CFG_ADDR
    |=> sfr_rdata_valid && sfr_rdata[4:2] == PCC_UNUSED_READ) else $error("unused bits");
  a_cfg_fields: assert property (cfg_wr |=> cycle_length_select == $past(sfr_wdata[1:0])
    && reload_bank_select == $past(sfr_wdata[7])) else $error("config fields");
  a_bank_steer: assert property (ce && sfr_wr && sfr_addr == PCC_CMP_LOW_ADDR[0]
    |=> compare_wr == !$past(reload_bank_select)) else $error("bank steering");
  a_reload_use: assert property (ce |=> reload_active ==
    ($past(channel_pwm_enable & ~wide_pwm_select) & {3{$past(cycle_length_select) != PCC_LEN8}}))
    else $error("reload use");
endmodule

bind pcc_top pcc_monitor i_pcc_monitor (.sys_clk, .rstn, .ce, .sfr_addr, .sfr_wdata, .sfr_wr,
  .sfr_rd, .sfr_rdata, .sfr_rdata_valid, .main_counter, .counter_tick, .channel_pwm_enable,
  .wide_pwm_select, .compare_wr, .reload_active, .reload_bank_select,
  .cycle_overflow_irq_enable, .cycle_overflow_flag, .cycle_length_select, .counter_array_irq);

/* File: tb/pcc_top_bench.sv */
// self-checking bench for the pwm cycle configuration block
module pcc_top_bench
  import pcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rstn = 0, ce = 1, sfr_wr = 0, sfr_rd = 0, counter_tick = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, compare_wr_data;
  logic [15:0] main_counter = 16'h0000;
  logic [15:0] compare_value [PCC_CHANNELS] = '{16'h1234, 16'h0000, 16'h9876};
  logic [15:0] reload_value [PCC_CHANNELS];
  logic [2:0] channel_pwm_enable = 3'h7, wide_pwm_select = 3'h2, reload_active, uses_cycle_length;
  logic sfr_rdata_valid, compare_wr, compare_wr_high, reload_bank_select, cycle_overflow_flag;
  logic cycle_overflow_irq_enable, counter_array_irq;
  logic [1:0] compare_wr_chan;
  pcc_len_type cycle_length_select;
  int mismatches = 0, checks_done = 0;
  pcc_top i_pcc_top (.sys_clk, .rstn, .ce, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
    .sfr_rdata_valid, .main_counter, .counter_tick, .channel_pwm_enable, .wide_pwm_select,
    .compare_value, .compare_wr, .compare_wr_chan, .compare_wr_high, .compare_wr_data,
    .reload_value, .reload_active, .uses_cycle_length, .reload_bank_select,
    .cycle_overflow_irq_enable, .cycle_overflow_flag, .cycle_length_select, .counter_array_irq);
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle strobe, drivers change on the rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic v, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    @(negedge sys_clk);
    chk(sfr_rdata_valid, v);
    if (v) chk(sfr_rdata, d);
  endtask
  task automatic tick(input logic [15:0] c);
    @(posedge sys_clk);
    main_counter <= c;
    counter_tick <= 1'b1;
    @(posedge sys_clk);
    counter_tick <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(PCC_CFG_ADDR, 1'b1, PCC_CFG_RESET);
    wr(PCC_CFG_ADDR, 8'hFF);
    rd(PCC_CFG_ADDR, 1'b1, 8'hE3);
    chk(counter_array_irq, 1'b1);
    wr(PCC_CFG_ADDR, 8'h43);
    chk({cycle_overflow_flag, counter_array_irq}, 2'b00);
    $display("test fields done");
    for (int l = 0; l < 4; l++) begin
      wr(PCC_CFG_ADDR, {6'h00, l[1:0]});
      tick({5'h00, PCC_LEN_MASK[l] >> 1});
      chk(cycle_overflow_flag, 1'b0);
      tick({5'h1F, PCC_LEN_MASK[l]});
      chk({cycle_overflow_flag, counter_array_irq}, 2'b10);
    end
    wr(PCC_CFG_ADDR, 8'h40);
    tick(16'h00FF);
    chk({cycle_overflow_flag, counter_array_irq}, 2'b11);
    $display("test overflow done");
    wr(PCC_CFG_ADDR, 8'h00);
    wr(PCC_CMP_LOW_ADDR[0], 8'h5A);
    chk({compare_wr, compare_wr_chan, compare_wr_high, compare_wr_data}, 12'h85A);
    wr(PCC_CMP_HIGH_ADDR[2], 8'hC3);
    chk({compare_wr, compare_wr_chan, compare_wr_high, compare_wr_data}, 12'hDC3);
    rd(PCC_CMP_HIGH_ADDR[0], 1'b1, 8'h12);
    rd(PCC_CMP_LOW_ADDR[2], 1'b1, 8'h76);
    wr(PCC_CFG_ADDR, 8'h81);
    wr(PCC_CMP_LOW_ADDR[0], 8'hA5);
    chk(compare_wr, 1'b0);
    wr(PCC_CMP_HIGH_ADDR[0], 8'h3C);
    @(negedge sys_clk);
    chk(reload_value[0], 16'h3CA5);
    rd(PCC_CMP_LOW_ADDR[0], 1'b1, 8'hA5);
    chk({reload_active, uses_cycle_length}, 6'h2D);
    wr(PCC_CFG_ADDR, 8'h00);
    @(negedge sys_clk);
    chk({reload_active, uses_cycle_length}, 6'h05);
    rd(8'h00, 1'b0, 8'h00);
    $display("test bank done");
    // clock enable low freezes flag and fields
    @(posedge sys_clk);
    ce <= 1'b0;
    tick(16'h00FF);
    wr(PCC_CFG_ADDR, 8'h60);
    chk({cycle_overflow_flag, cycle_overflow_irq_enable, counter_array_irq}, 3'h0);
    @(posedge sys_clk);
    ce <= 1'b1;
    tick(16'h00FF);
    chk(cycle_overflow_flag, 1'b1);
    $display("test enable done");
    // reset in mid-run returns everything to reset values
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    chk(reload_value[0], {PCC_RELOAD_RESET, PCC_RELOAD_RESET});
    chk({cycle_overflow_flag, counter_array_irq}, 2'b00);
    rd(PCC_CFG_ADDR, 1'b1, PCC_CFG_RESET);
    $display("test reset done");
    print_verdict();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
endmodule
